// ### bsse_pkg.sv
// constants and types for the branch, skip, shift and bit execution slice
package bsse_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int OFS_W = 7;
    localparam int BIT_W = 3;
    localparam int REG_AW = 5;
    localparam int IO_AW = 5;
    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam int MSB = 7;
    localparam int HMSB = 3;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP_ONE = 12'h001;
    localparam logic [PC_W-1:0] PC_STEP_TWO = 12'h002;
    localparam logic [PC_W-1:0] PC_STEP_THREE = 12'h003;
    localparam int LSB = 0;
    // extra stall cycles after a taken op
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [1:0] WAIT_TWO = 2'h2;
    // operations of this slice
    typedef enum logic [4:0] {
        BSSE_OP_NONE,
        BSSE_OP_COMPARE_WITH_CARRY_IN,
        BSSE_OP_COMPARE_WITH_IMMEDIATE,
        BSSE_OP_SKIP_IF_REG_BIT_ZERO,
        BSSE_OP_SKIP_IF_REG_BIT_ONE,
        BSSE_OP_SKIP_IF_IO_BIT_ZERO,
        BSSE_OP_SKIP_IF_IO_BIT_ONE,
        BSSE_OP_BRANCH_FLAG_ONE,
        BSSE_OP_BRANCH_FLAG_ZERO,
        BSSE_OP_BRANCH_SIGNED_GREATER_EQUAL,
        BSSE_OP_BRANCH_SIGNED_BELOW,
        BSSE_OP_SET_IO_BIT,
        BSSE_OP_CLEAR_IO_BIT,
        BSSE_OP_SHIFT_LEFT_LOGICAL,
        BSSE_OP_SHIFT_RIGHT_LOGICAL,
        BSSE_OP_ROTATE_LEFT_VIA_CARRY,
        BSSE_OP_ROTATE_RIGHT_VIA_CARRY
    } bsse_op_t;
    typedef enum {
        BSSE_ST_IDLE,
        BSSE_ST_WAIT
    } bsse_state_t;
endpackage

// ### bsse_exec.sv
// execution slice: compares, skips, flag branches, i/o bit set/clear, shifts
`timescale 1ns/1ps
`default_nettype none
// How it works
// - compare register minus immediate or register minus register minus carry; set z n v c h, no write
// - register bit zero skips next instruction, pc plus 2 or 3, flags kept
// - register bit one skips next instruction, pc plus 2 or 3, flags kept
// - i/o bit zero skips next instruction, pc plus 2 or 3, flags kept
// - i/o bit one skips next instruction, pc plus 2 or 3, flags kept
// - selected status flag one: pc becomes pc plus offset plus one
// - selected status flag zero: branch taken; one cycle untaken, two taken
// - equal and unequal branches test the zero flag
// - carry-set and unsigned-below branches taken when carry is one
// - carry-clear and unsigned higher-or-same taken when carry is zero
// - minus branch on negative one, plus branch on negative zero
// - signed greater-or-equal taken when negative xor overflow is zero
// - signed below taken when negative xor overflow is one
// - half-carry branches, taken on flag one or flag zero
// - transfer bit branches, taken on flag one or flag zero
// - overflow branches, taken on flag one or flag zero
// - interrupt enable branches, taken when enabled or disabled
// - set addressed i/o bit, flags kept, two cycles
// - clear addressed i/o bit, flags kept, two cycles
// - shift left, zero into bit 0, update z c n v
// - shift right, zero into bit 7, update z c n v
// - rotate left through carry, old bit 7 to carry
// - rotate right through carry, old bit 0 to carry, one cycle
module bsse_exec
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire bsse_pkg::bsse_op_t op_code,
    input wire logic [bsse_pkg::DATA_W-1:0] rd_data,
    input wire logic [bsse_pkg::DATA_W-1:0] rr_data,
    input wire logic [bsse_pkg::DATA_W-1:0] imm_data,
    input wire logic [bsse_pkg::BIT_W-1:0] bit_sel,
    input wire logic [bsse_pkg::OFS_W-1:0] branch_ofs,
    input wire logic next_is_two_word,
    input wire logic [bsse_pkg::IO_AW-1:0] io_addr,
    input wire logic [bsse_pkg::DATA_W-1:0] io_rdata,
    input wire logic [bsse_pkg::REG_AW-1:0] rd_addr,
    output logic [bsse_pkg::PC_W-1:0] pc_out,
    output logic [bsse_pkg::DATA_W-1:0] flags_out,
    output logic busy,
    output logic rf_we,
    output logic [bsse_pkg::REG_AW-1:0] rf_waddr,
    output logic [bsse_pkg::DATA_W-1:0] rf_wdata,
    output logic io_we,
    output logic [bsse_pkg::IO_AW-1:0] io_waddr,
    output logic [bsse_pkg::DATA_W-1:0] io_wdata
);
    import bsse_pkg::*;

    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [DATA_W-1:0] flags_reg;
    logic [DATA_W-1:0] flags_next;
    bsse_state_t state_reg;
    logic [1:0] wait_reg;
    logic [1:0] wait_next;
    logic rf_we_reg;
    logic [REG_AW-1:0] rf_waddr_reg;
    logic [DATA_W-1:0] rf_wdata_reg;
    logic io_we_reg;
    logic io_we_next;
    logic [IO_AW-1:0] io_waddr_reg;
    logic [DATA_W-1:0] io_wdata_reg;
    logic [DATA_W-1:0] io_wdata_next;
    logic [DATA_W-1:0] res;
    logic res_wr;
    logic [PC_W-1:0] ofs_ext;
    logic [PC_W-1:0] skip_step;
    logic [PC_W-1:0] branch_target;
    logic busy_reg;

    // select one bit of a byte
    function automatic logic bit_of(input logic [DATA_W-1:0] v, input logic [BIT_W-1:0] b);
        bit_of = v[b];
    endfunction

    // stall length of a taken skip, one more past a two-word instruction
    function automatic logic [1:0] skip_wait(input logic two_word);
        skip_wait = two_word ? WAIT_TWO : WAIT_ONE;
    endfunction

    // signed compare outcome held in the flags: negative xor overflow
    function automatic logic signed_lt(input logic [DATA_W-1:0] f);
        signed_lt = f[FLAG_N] ^ f[FLAG_V];
    endfunction

    // flag branch decode: selected status flag equals the wanted level
    function automatic logic flag_hit(input logic [DATA_W-1:0] f, input logic [BIT_W-1:0] b, input logic want);
        flag_hit = (f[b] == want);
    endfunction

    // flags for shift/rotate results: z n v, carry given
    function automatic logic [DATA_W-1:0] shift_flags(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] r,
        input logic c);
        logic [DATA_W-1:0] o;
        o = f;
        o[FLAG_C] = c;
        o[FLAG_Z] = (r == '0);
        o[FLAG_N] = r[MSB];
        o[FLAG_V] = r[MSB] ^ c;
        o[FLAG_S] = r[MSB] ^ (r[MSB] ^ c);
        shift_flags = o;
    endfunction

    // subtract without write back, flags from the difference
    function automatic logic [DATA_W-1:0] cmp_flags(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b, input logic cin, input logic keep_z);
        logic [DATA_W-1:0] o;
        logic [DATA_W-1:0] d;
        o = f;
        d = a - b - {{(DATA_W-1){1'b0}}, cin};
        o[FLAG_H] = (~a[HMSB] & b[HMSB]) | (b[HMSB] & d[HMSB]) | (d[HMSB] & ~a[HMSB]);
        o[FLAG_C] = (~a[MSB] & b[MSB]) | (b[MSB] & d[MSB]) | (d[MSB] & ~a[MSB]);
        o[FLAG_V] = (a[MSB] & ~b[MSB] & ~d[MSB]) | (~a[MSB] & b[MSB] & d[MSB]);
        o[FLAG_N] = d[MSB];
        o[FLAG_S] = d[MSB] ^ o[FLAG_V];
        o[FLAG_Z] = keep_z ? ((d == '0) & f[FLAG_Z]) : (d == '0);
        cmp_flags = o;
    endfunction

    assign ofs_ext = {{(PC_W-OFS_W){branch_ofs[OFS_W-1]}}, branch_ofs};
    assign skip_step = next_is_two_word ? PC_STEP_THREE : PC_STEP_TWO;
    assign branch_target = pc_reg + ofs_ext + PC_STEP_ONE;

    always_comb
    begin
        pc_next = pc_reg + PC_STEP_ONE;
        flags_next = flags_reg;
        wait_next = WAIT_NONE;
        res = rd_data;
        res_wr = 1'b0;
        io_we_next = 1'b0;
        io_wdata_next = io_rdata;
        if (op_valid && state_reg == BSSE_ST_IDLE)
        begin
            unique case (op_code)
                BSSE_OP_COMPARE_WITH_CARRY_IN:
                    flags_next = cmp_flags(flags_reg, rd_data, rr_data, flags_reg[FLAG_C], 1'b1);
                BSSE_OP_COMPARE_WITH_IMMEDIATE:
                    flags_next = cmp_flags(flags_reg, rd_data, imm_data, 1'b0, 1'b0);
                BSSE_OP_SKIP_IF_REG_BIT_ZERO:
                    if (!bit_of(rr_data, bit_sel))
                    begin
                        pc_next = pc_reg + skip_step;
                        wait_next = skip_wait(next_is_two_word);
                    end
                BSSE_OP_SKIP_IF_REG_BIT_ONE:
                    if (bit_of(rr_data, bit_sel))
                    begin
                        pc_next = pc_reg + skip_step;
                        wait_next = skip_wait(next_is_two_word);
                    end
                BSSE_OP_SKIP_IF_IO_BIT_ZERO:
                    if (!bit_of(io_rdata, bit_sel))
                    begin
                        pc_next = pc_reg + skip_step;
                        wait_next = skip_wait(next_is_two_word);
                    end
                BSSE_OP_SKIP_IF_IO_BIT_ONE:
                    if (bit_of(io_rdata, bit_sel))
                    begin
                        pc_next = pc_reg + skip_step;
                        wait_next = skip_wait(next_is_two_word);
                    end
                // covers equal, carry, negative, half-carry, transfer, overflow, interrupt forms
                BSSE_OP_BRANCH_FLAG_ONE:
                    if (flag_hit(flags_reg, bit_sel, 1'b1))
                    begin
                        pc_next = branch_target;
                        wait_next = WAIT_ONE;
                    end
                BSSE_OP_BRANCH_FLAG_ZERO:
                    if (flag_hit(flags_reg, bit_sel, 1'b0))
                    begin
                        pc_next = branch_target;
                        wait_next = WAIT_ONE;
                    end
                BSSE_OP_BRANCH_SIGNED_GREATER_EQUAL:
                    if (!signed_lt(flags_reg))
                    begin
                        pc_next = branch_target;
                        wait_next = WAIT_ONE;
                    end
                BSSE_OP_BRANCH_SIGNED_BELOW:
                    if (signed_lt(flags_reg))
                    begin
                        pc_next = branch_target;
                        wait_next = WAIT_ONE;
                    end
                BSSE_OP_SET_IO_BIT:
                begin
                    io_wdata_next[bit_sel] = 1'b1;
                    io_we_next = 1'b1;
                    wait_next = WAIT_ONE;
                end
                BSSE_OP_CLEAR_IO_BIT:
                begin
                    io_wdata_next[bit_sel] = 1'b0;
                    io_we_next = 1'b1;
                    wait_next = WAIT_ONE;
                end
                BSSE_OP_SHIFT_LEFT_LOGICAL:
                begin
                    res = {rd_data[MSB-1:0], 1'b0};
                    res_wr = 1'b1;
                    flags_next = shift_flags(flags_reg, res, rd_data[MSB]);
                end
                BSSE_OP_SHIFT_RIGHT_LOGICAL:
                begin
                    res = {1'b0, rd_data[MSB:LSB+1]};
                    res_wr = 1'b1;
                    flags_next = shift_flags(flags_reg, res, rd_data[LSB]);
                end
                BSSE_OP_ROTATE_LEFT_VIA_CARRY:
                begin
                    res = {rd_data[MSB-1:0], flags_reg[FLAG_C]};
                    res_wr = 1'b1;
                    flags_next = shift_flags(flags_reg, res, rd_data[MSB]);
                end
                BSSE_OP_ROTATE_RIGHT_VIA_CARRY:
                begin
                    res = {flags_reg[FLAG_C], rd_data[MSB:LSB+1]};
                    res_wr = 1'b1;
                    flags_next = shift_flags(flags_reg, res, rd_data[LSB]);
                end
                default:
                    pc_next = pc_reg + PC_STEP_ONE;
            endcase
        end
        else if (!op_valid || state_reg == BSSE_ST_WAIT)
        begin
            pc_next = pc_reg;
        end
    end

    // program counter
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pc_reg <= PC_RESET;
        end
        else
        begin
            pc_reg <= pc_next;
        end
    end

    // status flags, changed only by compares, shifts and rotates
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_reg <= FLAGS_RESET;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    // multi-cycle stall: extra cycles for taken branch, skip and i/o bit write
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= BSSE_ST_IDLE;
            wait_reg <= WAIT_NONE;
        end
        else if (state_reg == BSSE_ST_IDLE)
        begin
            wait_reg <= wait_next;
            if (wait_next != WAIT_NONE)
            begin
                state_reg <= BSSE_ST_WAIT;
            end
        end
        else
        begin
            wait_reg <= wait_reg - WAIT_ONE;
            if (wait_reg == WAIT_ONE)
            begin
                state_reg <= BSSE_ST_IDLE;
            end
        end
    end

    // busy kept in its own flop so the port needs no decode
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_reg <= 1'b0;
        end
        else if (state_reg == BSSE_ST_IDLE)
        begin
            busy_reg <= (wait_next != WAIT_NONE);
        end
        else
        begin
            busy_reg <= (wait_reg != WAIT_ONE);
        end
    end

    // register file write strobe for shifts and rotates
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rf_we_reg <= 1'b0;
        end
        else
        begin
            rf_we_reg <= res_wr;
        end
    end

    // register file write address and result
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rf_waddr_reg <= '0;
            rf_wdata_reg <= '0;
        end
        else
        begin
            rf_waddr_reg <= rd_addr;
            rf_wdata_reg <= res;
        end
    end

    // i/o write strobe for bit set and clear
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            io_we_reg <= 1'b0;
        end
        else
        begin
            io_we_reg <= io_we_next;
        end
    end

    // i/o read-modify-write address and byte
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            io_waddr_reg <= '0;
            io_wdata_reg <= '0;
        end
        else
        begin
            io_waddr_reg <= io_addr;
            io_wdata_reg <= io_wdata_next;
        end
    end

    assign pc_out = pc_reg;
    assign flags_out = flags_reg;
    assign busy = busy_reg;
    assign rf_we = rf_we_reg;
    assign rf_waddr = rf_waddr_reg;
    assign rf_wdata = rf_wdata_reg;
    assign io_we = io_we_reg;
    assign io_waddr = io_waddr_reg;
    assign io_wdata = io_wdata_reg;
endmodule
`default_nettype wire

// ### bsse_exec_checker.sv
// concurrent checks on the ports of the execution slice
`timescale 1ns/1ps
`default_nettype none
module bsse_exec_checker
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire bsse_pkg::bsse_op_t op_code,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] rr_data,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    input wire logic [6:0] branch_ofs,
    input wire logic next_is_two_word,
    input wire logic [4:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic [4:0] rd_addr,
    input wire logic [11:0] pc_out,
    input wire logic [7:0] flags_out,
    input wire logic busy,
    input wire logic rf_we,
    input wire logic [4:0] rf_waddr,
    input wire logic [7:0] rf_wdata,
    input wire logic io_we,
    input wire logic [4:0] io_waddr,
    input wire logic [7:0] io_wdata
);
    import bsse_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    property p_busy_len; busy ##1 busy |=> !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_hold; busy |=> $stable(pc_out) && $stable(flags_out); endproperty
    a_hold: assert property (p_hold) else $error("state moved while busy");
    property p_io_pulse; io_we |-> busy && !rf_we; endproperty
    a_io_pulse: assert property (p_io_pulse) else $error("io write not two cycles");
    property p_set; io_we && $past(op_code) == BSSE_OP_SET_IO_BIT |->
        io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_sel))) && io_waddr == $past(io_addr); endproperty
    a_set: assert property (p_set) else $error("io bit set wrong");
    property p_lsl; rf_we && $past(op_code) == BSSE_OP_SHIFT_LEFT_LOGICAL |->
        rf_wdata == {$past(rd_data[6:0]), 1'b0} && flags_out[FLAG_C] == $past(rd_data[7]); endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_ror; rf_we && $past(op_code) == BSSE_OP_ROTATE_RIGHT_VIA_CARRY |->
        rf_wdata == {$past(flags_out[FLAG_C]), $past(rd_data[7:1])} && flags_out[FLAG_C] == $past(rd_data[0]); endproperty
    a_ror: assert property (p_ror) else $error("right rotate wrong");
    property p_branch; !busy && op_valid && op_code == BSSE_OP_BRANCH_FLAG_ZERO && !flags_out[bit_sel] |=> busy &&
        pc_out == $past(pc_out) + {{5{$past(branch_ofs[6])}}, $past(branch_ofs)} + 12'h001 && $stable(flags_out); endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_skip; !busy && op_valid && op_code == BSSE_OP_SKIP_IF_IO_BIT_ONE && io_rdata[bit_sel] |=>
        pc_out == $past(pc_out) + ($past(next_is_two_word) ? 12'h003 : 12'h002); endproperty
    a_skip: assert property (p_skip) else $error("skip distance wrong");
endmodule
`default_nettype wire

// ### tb.sv
// self-checking testbench for the execution slice
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bsse_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    bsse_op_t op_code = BSSE_OP_NONE;
    logic [7:0] rd_data = 8'h00, rr_data = 8'h00, imm_data = 8'h00, io_rdata = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [6:0] branch_ofs = 7'h00;
    logic next_is_two_word = 1'b0;
    logic [4:0] io_addr = 5'h00, rd_addr = 5'h00, rf_waddr, io_waddr;
    logic [11:0] pc_out, m_pc;
    logic [7:0] flags_out, rf_wdata, io_wdata, m_flags;
    logic busy, rf_we, io_we;
    int mismatches = 0;
    int comparisons = 0;
    logic [11:0] exp_q[$];
    always #4 ref_clk = ~ref_clk;
    bsse_exec dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
        .rd_data(rd_data), .rr_data(rr_data), .imm_data(imm_data), .bit_sel(bit_sel), .branch_ofs(branch_ofs),
        .next_is_two_word(next_is_two_word), .io_addr(io_addr), .io_rdata(io_rdata), .rd_addr(rd_addr),
        .pc_out(pc_out), .flags_out(flags_out), .busy(busy), .rf_we(rf_we), .rf_waddr(rf_waddr),
        .rf_wdata(rf_wdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // drive one random operation, predict its effect and compare
    task automatic run(input bsse_op_t op);
        logic [11:0] np;
        logic [7:0] s, r, f, wd;
        logic tk, c, cmp, sh, io;
        int extra, cnt;
        op_valid <= 1'b1;
        op_code <= op;
        {rd_data, rr_data, imm_data, io_rdata} <= $urandom;
        {bit_sel, branch_ofs, next_is_two_word, io_addr, rd_addr} <= 21'($urandom);
        @(posedge ref_clk);
        #1;
        f = m_flags;
        np = m_pc + 12'h001;
        extra = 0;
        tk = 1'b0;
        r = 8'h00;
        c = 1'b0;
        wd = 8'h00;
        cmp = op inside {BSSE_OP_COMPARE_WITH_CARRY_IN, BSSE_OP_COMPARE_WITH_IMMEDIATE};
        sh = op >= BSSE_OP_SHIFT_LEFT_LOGICAL;
        io = op inside {BSSE_OP_SET_IO_BIT, BSSE_OP_CLEAR_IO_BIT};
        case (op)
            BSSE_OP_COMPARE_WITH_CARRY_IN, BSSE_OP_COMPARE_WITH_IMMEDIATE:
            begin
                s = (op == BSSE_OP_COMPARE_WITH_IMMEDIATE) ? imm_data : rr_data;
                r = 8'(rd_data - s - ((op == BSSE_OP_COMPARE_WITH_CARRY_IN) & m_flags[FLAG_C]));
                f[FLAG_H] = (~rd_data[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~rd_data[3]);
                f[FLAG_V] = (rd_data[7] & ~s[7] & ~r[7]) | (~rd_data[7] & s[7] & r[7]);
                c = (~rd_data[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~rd_data[7]);
            end
            BSSE_OP_SKIP_IF_REG_BIT_ZERO, BSSE_OP_SKIP_IF_REG_BIT_ONE,
            BSSE_OP_SKIP_IF_IO_BIT_ZERO, BSSE_OP_SKIP_IF_IO_BIT_ONE:
            begin
                if ((op inside {BSSE_OP_SKIP_IF_REG_BIT_ONE, BSSE_OP_SKIP_IF_IO_BIT_ONE}) ==
                    (op < BSSE_OP_SKIP_IF_IO_BIT_ZERO ? rr_data[bit_sel] : io_rdata[bit_sel]))
                begin
                    np = m_pc + (next_is_two_word ? 12'h003 : 12'h002);
                    extra = next_is_two_word ? 2 : 1;
                end
            end
            BSSE_OP_BRANCH_FLAG_ONE: tk = m_flags[bit_sel];
            BSSE_OP_BRANCH_FLAG_ZERO: tk = !m_flags[bit_sel];
            BSSE_OP_BRANCH_SIGNED_GREATER_EQUAL: tk = !(m_flags[FLAG_N] ^ m_flags[FLAG_V]);
            BSSE_OP_BRANCH_SIGNED_BELOW: tk = m_flags[FLAG_N] ^ m_flags[FLAG_V];
            BSSE_OP_SET_IO_BIT: wd = io_rdata | (8'h01 << bit_sel);
            BSSE_OP_CLEAR_IO_BIT: wd = io_rdata & ~(8'h01 << bit_sel);
            BSSE_OP_SHIFT_LEFT_LOGICAL: {c, r} = {rd_data, 1'b0};
            BSSE_OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, rd_data};
            BSSE_OP_ROTATE_LEFT_VIA_CARRY: {c, r} = {rd_data, m_flags[FLAG_C]};
            BSSE_OP_ROTATE_RIGHT_VIA_CARRY: {r, c} = {m_flags[FLAG_C], rd_data};
            default: ;
        endcase
        if (tk || io)
            extra = 1;
        if (tk)
            np = m_pc + {{5{branch_ofs[6]}}, branch_ofs} + 12'h001;
        if (cmp || sh)
        begin
            if (sh)
                f[FLAG_V] = r[7] ^ c;
            f[FLAG_C] = c;
            f[FLAG_N] = r[7];
            f[FLAG_Z] = (r == 8'h00) && (op != BSSE_OP_COMPARE_WITH_CARRY_IN || m_flags[FLAG_Z]);
            f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        end
        exp_q.push_back(np);
        chk("pc and flags", {pc_out, flags_out}, {np, f});
        chk("busy rf_we io_we", {busy, rf_we, io_we}, {extra != 0, sh, io});
        if (sh)
            chk("rf write", {rf_waddr, rf_wdata}, {rd_addr, r});
        if (io)
            chk("io write", {io_waddr, io_wdata}, {io_addr, wd});
        cnt = 0;
        while (busy === 1'b1 && cnt < 4)
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
        chk("busy cycles", 24'(cnt), 24'(extra));
        chk("pc held", pc_out, exp_q.pop_front());
        if (cnt == 4)
            tally_and_finish();
        m_pc = np;
        m_flags = f;
    endtask
    initial
    begin
        void'($urandom(32'h2449));
        m_pc = 12'h000;
        m_flags = 8'h00;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        repeat (1500) run(bsse_op_t'($urandom_range(16, 0)));
        op_valid <= 1'b0;
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("reset state", {pc_out, flags_out}, 24'h000000);
        chk("reset outputs", {busy, rf_we, io_we, rf_wdata, io_wdata}, 24'h000000);
        sys_rst <= 1'b0;
        m_pc = 12'h000;
        m_flags = 8'h00;
        @(posedge ref_clk);
        repeat (300) run(bsse_op_t'($urandom_range(16, 0)));
        tally_and_finish();
    end
endmodule
bind bsse_exec bsse_exec_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .rd_data(rd_data), .rr_data(rr_data), .imm_data(imm_data), .bit_sel(bit_sel),
    .branch_ofs(branch_ofs), .next_is_two_word(next_is_two_word), .io_addr(io_addr), .io_rdata(io_rdata),
    .rd_addr(rd_addr), .pc_out(pc_out), .flags_out(flags_out), .busy(busy), .rf_we(rf_we),
    .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));
`default_nettype wire
